//--- design/dso_pkg.sv
/*
 package of the dual-lane serial sample output block: widths, test word,
 bit counter marks, configuration bit positions, register map and bus
 responses. assumes nothing of its surroundings.
*/
package dso_pkg;
   // ------------------------------------------------------------
   // word and lane timing
   // ------------------------------------------------------------
   localparam int WORD_W = 12;
   localparam logic [11:0] TEST_WORD = 12'ha63;
   localparam int CNT_W = 4;
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_HALF = 4'h6;
   localparam logic [3:0] BIT_LAST = 4'hb;
   // ------------------------------------------------------------
   // configuration bits
   // ------------------------------------------------------------
   localparam int CFG_W = 5;
   localparam int CFG_PD_A = 0;
   localparam int CFG_PD_B = 1;
   localparam int CFG_TEST = 2;
   localparam int CFG_WAM = 3;
   localparam int CFG_SINGLE = 4;
   localparam int PIN_W = 6;
   localparam int PIN_EN = 5;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam int STAT_EN = 5;
   localparam int STAT_RDY = 6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- design/dso_serial_lane_output.sv
/*
 dual-channel 12-bit sample serializer with ddr serial clock, frame and
 one or two lanes per channel, static control pins and an axi4-lite slave.
 assumes samples arrive on clk, pins are asynchronous, and link_clk runs
 at twice the bit-pair rate, one lane bit per link_clk cycle.
*/
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module dso_serial_lane_output (
   input wire logic clk,
   input wire logic reset,
   input wire logic link_clk,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [dso_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [dso_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic control_port_enable,
   input wire logic powerdown_chan_a,
   input wire logic powerdown_chan_b,
   input wire logic test_pattern_select,
   input wire logic word_align_select,
   input wire logic lane_config_select,
   input wire logic [dso_pkg::WORD_W-1:0] sample_chan_a,
   input wire logic [dso_pkg::WORD_W-1:0] sample_chan_b,
   input wire logic sample_valid,
   output logic sample_ready,
   output logic serial_out_clock,
   output logic frame_out,
   output logic lane1_data_chan_a,
   output logic lane1_data_chan_b,
   output logic lane0_data_chan_a,
   output logic lane0_data_chan_b,
   output logic lane0_oe_chan_a,
   output logic lane0_oe_chan_b
);
   import dso_pkg::*;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [WORD_W-1:0] word_pick(input logic test,
                                                   input logic [WORD_W-1:0] smp);
      word_pick = test ? TEST_WORD : smp;
   endfunction

   function automatic logic [WORD_W-1:0] shl(input logic [WORD_W-1:0] w);
      shl = {w[WORD_W-2:0], 1'b0};
   endfunction

   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q;
   logic arready_q, rvalid_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q, rdata_q;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [CFG_W-1:0] ctrl_q, eff_cfg_q;
   logic [PIN_W-1:0] pin_meta_q, pin_q;
   logic sample_ready_q;
   logic aw_take, w_take, wr_fire, ar_take;

   assign aw_take = s_axi_awvalid && awready_q;
   assign w_take = s_axi_wvalid && wready_q;
   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   assign ar_take = s_axi_arvalid && arready_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         aw_hold_q <= 1'b0;
         awready_q <= 1'b0;
         aw_addr_q <= '0;
      end else begin
         if (aw_take) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
         end
         awready_q <= !(aw_take || (aw_hold_q && !wr_fire));
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         w_hold_q <= 1'b0;
         wready_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else begin
         if (w_take) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_hold_q <= 1'b0;
         end
         wready_q <= !(w_take || (w_hold_q && !wr_fire));
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         ctrl_q <= CTRL_RESET;
      end else begin
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (aw_addr_q == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
            if (aw_addr_q == ADDR_CTRL && w_strb_q[0]) begin
               ctrl_q <= w_data_q[CFG_W-1:0];
            end
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else begin
         if (ar_take) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            case (s_axi_araddr)
               ADDR_CTRL: rdata_q <= {27'h000_0000, ctrl_q};
               ADDR_STATUS: rdata_q <= {25'h000_0000, sample_ready_q, pin_q[PIN_EN],
                                        eff_cfg_q};
               default: begin
                  rdata_q <= 32'h0000_0000;
                  rresp_q <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
         arready_q <= !(ar_take || (rvalid_q && !s_axi_rready));
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers and effective configuration
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_meta_q <= '0;
         pin_q <= '0;
      end else begin
         pin_meta_q <= {control_port_enable, lane_config_select, word_align_select,
                        test_pattern_select, powerdown_chan_b, powerdown_chan_a};
         pin_q <= pin_meta_q;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         eff_cfg_q <= CTRL_RESET;
      end else begin
         eff_cfg_q <= pin_q[PIN_EN] ? ctrl_q : pin_q[CFG_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // sample handshake toward the link domain
   // ------------------------------------------------------------
   logic req_tgl_q, ack_meta_q, ack_sync_q, req_seen_q;
   logic [WORD_W-1:0] smp_a_q, smp_b_q;
   logic smp_take;

   assign smp_take = sample_valid && sample_ready_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         req_tgl_q <= 1'b0;
         ack_meta_q <= 1'b0;
         ack_sync_q <= 1'b0;
         sample_ready_q <= 1'b0;
         smp_a_q <= '0;
         smp_b_q <= '0;
      end else begin
         ack_meta_q <= req_seen_q;
         ack_sync_q <= ack_meta_q;
         if (smp_take) begin
            req_tgl_q <= !req_tgl_q;
            smp_a_q <= sample_chan_a;
            smp_b_q <= sample_chan_b;
         end
         sample_ready_q <= !smp_take && (ack_sync_q == req_tgl_q);
      end
   end

   // ------------------------------------------------------------
   // link domain: reset, configuration and sample capture
   // ------------------------------------------------------------
   logic lrst_meta_q, lrst_q, req_meta_q, req_sync_q, pend_valid_q;
   logic [CFG_W-1:0] cfg_meta_q, cfg_q;
   logic [WORD_W-1:0] pend_a_q, pend_b_q;
   logic pd_a, pd_b, run, single, offset, ld1, fetch0, ld0, cap;
   logic [CNT_W-1:0] bit_cnt_q;
   logic [WORD_W-1:0] pick_a, pick_b;

   always_ff @(posedge link_clk) begin
      lrst_meta_q <= reset;
      lrst_q <= lrst_meta_q;
   end

   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         cfg_meta_q <= CTRL_RESET;
         cfg_q <= CTRL_RESET;
      end else begin
         cfg_meta_q <= eff_cfg_q;
         cfg_q <= cfg_meta_q;
      end
   end

   assign pd_a = cfg_q[CFG_PD_A];
   assign pd_b = cfg_q[CFG_PD_B];
   assign run = !(pd_a && pd_b);
   assign single = cfg_q[CFG_SINGLE];
   assign offset = !single && !cfg_q[CFG_WAM];
   assign ld1 = run && (bit_cnt_q == BIT_FIRST);
   assign fetch0 = run && !single && (bit_cnt_q == BIT_HALF);
   assign ld0 = offset ? fetch0 : (ld1 && !single);
   assign cap = (req_sync_q != req_seen_q) && !pend_valid_q;
   assign pick_a = word_pick(cfg_q[CFG_TEST], pend_a_q);
   assign pick_b = word_pick(cfg_q[CFG_TEST], pend_b_q);

   // a sample that lands while the slot is consumed is kept for the next word
   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         req_meta_q <= 1'b0;
         req_sync_q <= 1'b0;
         req_seen_q <= 1'b0;
         pend_valid_q <= 1'b0;
         pend_a_q <= '0;
         pend_b_q <= '0;
      end else begin
         req_meta_q <= req_tgl_q;
         req_sync_q <= req_meta_q;
         if (cap) begin
            req_seen_q <= req_sync_q;
            pend_a_q <= smp_a_q;
            pend_b_q <= smp_b_q;
            pend_valid_q <= 1'b1;
         end else if (ld1 || fetch0) begin
            pend_valid_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // link domain: serial clock, frame and bit counter
   // ------------------------------------------------------------
   logic out_clk_q, frame_q;

   always_ff @(posedge link_clk) begin
      if (lrst_q || !run) begin
         out_clk_q <= 1'b0;
         frame_q <= 1'b0;
         bit_cnt_q <= BIT_FIRST;
      end else begin
         out_clk_q <= !bit_cnt_q[0];
         frame_q <= (bit_cnt_q < BIT_HALF);
         bit_cnt_q <= (bit_cnt_q == BIT_LAST) ? BIT_FIRST : bit_cnt_q + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // link domain: lane shifters
   // ------------------------------------------------------------
   logic l1_a_q, l1_b_q, l0_a_q, l0_b_q, oe0_q;
   logic [WORD_W-1:0] sh1_a_q, sh1_b_q, sh0_a_q, sh0_b_q, stg_a_q, stg_b_q;
   logic [WORD_W-1:0] w0_a, w0_b;

   assign w0_a = offset ? pick_a : stg_a_q;
   assign w0_b = offset ? pick_b : stg_b_q;

   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         l1_a_q <= 1'b0;
         sh1_a_q <= '0;
      end else if (!pd_a && run) begin
         if (ld1) begin
            l1_a_q <= pick_a[WORD_W-1];
            sh1_a_q <= shl(pick_a);
         end else begin
            l1_a_q <= sh1_a_q[WORD_W-1];
            sh1_a_q <= shl(sh1_a_q);
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         l1_b_q <= 1'b0;
         sh1_b_q <= '0;
      end else if (!pd_b && run) begin
         if (ld1) begin
            l1_b_q <= pick_b[WORD_W-1];
            sh1_b_q <= shl(pick_b);
         end else begin
            l1_b_q <= sh1_b_q[WORD_W-1];
            sh1_b_q <= shl(sh1_b_q);
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         stg_a_q <= '0;
         stg_b_q <= '0;
      end else if (fetch0) begin
         stg_a_q <= pick_a;
         stg_b_q <= pick_b;
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         l0_a_q <= 1'b0;
         sh0_a_q <= '0;
      end else if (!pd_a && run && !single) begin
         if (ld0) begin
            l0_a_q <= w0_a[WORD_W-1];
            sh0_a_q <= shl(w0_a);
         end else begin
            l0_a_q <= sh0_a_q[WORD_W-1];
            sh0_a_q <= shl(sh0_a_q);
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         l0_b_q <= 1'b0;
         sh0_b_q <= '0;
      end else if (!pd_b && run && !single) begin
         if (ld0) begin
            l0_b_q <= w0_b[WORD_W-1];
            sh0_b_q <= shl(w0_b);
         end else begin
            l0_b_q <= sh0_b_q[WORD_W-1];
            sh0_b_q <= shl(sh0_b_q);
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         oe0_q <= 1'b0;
      end else begin
         oe0_q <= !single;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign sample_ready = sample_ready_q;
   assign serial_out_clock = out_clk_q;
   assign frame_out = frame_q;
   assign lane1_data_chan_a = l1_a_q;
   assign lane1_data_chan_b = l1_b_q;
   assign lane0_data_chan_a = l0_a_q;
   assign lane0_data_chan_b = l0_b_q;
   assign lane0_oe_chan_a = oe0_q;
   assign lane0_oe_chan_b = oe0_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   AST_PINS_IGNORED: assert property (@(posedge clk) disable iff (reset)
      (pin_q[PIN_EN] && $past(pin_q[PIN_EN]) && !$past(reset))
      |-> eff_cfg_q == $past(ctrl_q))
      else $error("pins not overridden by control register");

   AST_PD_CLK_FRAME_LOW: assert property (@(posedge link_clk) disable iff (lrst_q)
      (pd_a && pd_b) |=> (!out_clk_q && !frame_q))
      else $error("clock or frame not low in power-down");

   AST_PD_FREEZE: assert property (@(posedge link_clk) disable iff (lrst_q)
      pd_a |=> ($stable(l1_a_q) && $stable(l0_a_q)))
      else $error("lane moved during power-down");

   AST_LANE0_OFF: assert property (@(posedge link_clk) disable iff (lrst_q)
      single |=> !oe0_q)
      else $error("lane0 driven in single-lane mode");

   AST_DDR_TOGGLE: assert property (@(posedge link_clk) disable iff (lrst_q)
      (run && $past(run) && !$past(lrst_q)) |=> (out_clk_q != $past(out_clk_q)))
      else $error("serial clock failed to toggle");

   AST_FRAME_RISE: assert property (@(posedge link_clk) disable iff (lrst_q)
      $rose(frame_q) |-> ($past(bit_cnt_q) == BIT_FIRST))
      else $error("frame rose off a word boundary");

   AST_FRAME_FALL: assert property (@(posedge link_clk) disable iff (lrst_q)
      ($fell(frame_q) && run) |-> ($past(bit_cnt_q) == BIT_HALF))
      else $error("frame fell off the half-word point");

   AST_TEST_WORD: assert property (@(posedge link_clk) disable iff (lrst_q)
      (ld1 && cfg_q[CFG_TEST] && !pd_a && $stable(cfg_q))
      |=> (l1_a_q == TEST_WORD[11]) ##1 ($past(pd_a) || (l1_a_q == TEST_WORD[10])))
      else $error("test word not sent");

   AST_MSB_FIRST: assert property (@(posedge link_clk) disable iff (lrst_q)
      (ld1 && !pd_b && $stable(cfg_q))
      |=> (l1_b_q == $past(pick_b[11]))
      ##1 ($past(pd_b) || (l1_b_q == $past(pick_b[10], 2))))
      else $error("word not sent msb first");

   AST_OFFSET_LOAD: assert property (@(posedge link_clk) disable iff (lrst_q)
      (fetch0 && offset && !pd_a && $stable(cfg_q)) |=> (l0_a_q == $past(pick_a[11])))
      else $error("offset lane0 word not started at half word");

   AST_ALIGN_LOAD: assert property (@(posedge link_clk) disable iff (lrst_q)
      (ld1 && !offset && !single && !pd_a && $stable(cfg_q))
      |=> (l0_a_q == $past(stg_a_q[11])))
      else $error("aligned lane0 word not started with lane1");

   CVR_OFFSET: cover property (@(posedge link_clk) disable iff (lrst_q)
      fetch0 && offset && !pd_a);
   CVR_ALIGNED: cover property (@(posedge link_clk) disable iff (lrst_q)
      ld1 && !offset && !single);
   CVR_SINGLE_TEST: cover property (@(posedge link_clk) disable iff (lrst_q)
      ld1 && single && cfg_q[CFG_TEST]);
   CVR_POWERDOWN: cover property (@(posedge link_clk) disable iff (lrst_q)
      run ##1 !run);
endmodule
`default_nettype wire

//--- testbench/dso_rx_model.sv
/*
 receiver model of the serial lane outputs: shifts every lane and latches
 the last 12 bits at each frame edge; counts words and clock toggles.
 assumes outputs change on the rising link clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module dso_rx_model (
   input wire logic link_clk,
   input wire logic serial_out_clock,
   input wire logic frame_out,
   input wire logic [3:0] lanes,
   output logic [11:0] cap_r [4],
   output logic [11:0] cap_f [4],
   output int words,
   output int tog
);
   logic [11:0] sh [4];
   logic frame_p = 1'b0;
   logic sclk_p = 1'b0;
   // ----
   // sample in mid bit
   // ----
   always @(negedge link_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (frame_out && !frame_p) begin
            cap_r[i] <= sh[i];
         end
         if (!frame_out && frame_p) begin
            cap_f[i] <= sh[i];
         end
         sh[i] <= {sh[i][10:0], lanes[i]};
      end
      if (frame_out && !frame_p) begin
         words <= words + 1;
      end
      if (serial_out_clock !== sclk_p) begin
         tog <= tog + 1;
      end
      frame_p <= frame_out;
      sclk_p <= serial_out_clock;
   end
   initial begin
      words = 0;
      tog = 0;
   end
endmodule
`default_nettype wire

//--- testbench/tb.sv
/*
 testbench of the serial lane output: register access over axi4-lite,
 pin sequences and checks on the received lane words.
 assumes the receiver model on the link outputs.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   import dso_pkg::*;
   localparam logic [11:0] SMP_A = 12'h5c3;
   localparam logic [11:0] SMP_B = 12'h1e7;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset = 1'b1;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [3:0] s_axi_wstrb, lanes;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r, held;
   logic control_port_enable, powerdown_chan_a, powerdown_chan_b, test_pattern_select;
   logic word_align_select, lane_config_select, sample_valid, sample_ready;
   logic [11:0] sample_chan_a, sample_chan_b;
   logic serial_out_clock, frame_out, lane1_data_chan_a, lane1_data_chan_b;
   logic lane0_data_chan_a, lane0_data_chan_b, lane0_oe_chan_a, lane0_oe_chan_b;
   logic [11:0] cap_r [4];
   logic [11:0] cap_f [4];
   int words, tog, t0;
   int num_errors = 0;
   int total_checks = 0;
   always #50 clk = ~clk;
   initial begin
      #13;
      forever #32 link_clk = ~link_clk;
   end
   // undriven lane0 shows the inverse level
   assign lanes[0] = lane1_data_chan_a;
   assign lanes[1] = lane1_data_chan_b;
   assign lanes[2] = lane0_oe_chan_a ? lane0_data_chan_a : ~lane0_data_chan_a;
   assign lanes[3] = lane0_oe_chan_b ? lane0_data_chan_b : ~lane0_data_chan_b;
   dso_serial_lane_output u_dut (.clk, .reset, .link_clk, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .control_port_enable,
      .powerdown_chan_a, .powerdown_chan_b, .test_pattern_select, .word_align_select,
      .lane_config_select, .sample_chan_a, .sample_chan_b, .sample_valid, .sample_ready,
      .serial_out_clock, .frame_out, .lane1_data_chan_a, .lane1_data_chan_b,
      .lane0_data_chan_a, .lane0_data_chan_b, .lane0_oe_chan_a, .lane0_oe_chan_b);
   dso_rx_model u_rx (.link_clk, .serial_out_clock, .frame_out, .lanes, .cap_r, .cap_f,
      .words, .tog);
   // ----
   // tasks
   // ----
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic hang(input string what);
      num_errors++;
      $display("Error at %0t: timeout in %s", $time, what);
      complete_run();
   endtask
   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] v,
                         output logic [1:0] rsp);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 40);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 40) hang("write");
   endtask
   task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] v,
                         output logic [1:0] rsp);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 40);
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 40) hang("read");
   endtask
   task automatic wait_words(input int k);
      int n, w;
      w = words;
      for (n = 0; n < 60 * k && words < w + k; n++) @(posedge link_clk);
      if (words < w + k) hang("link words");
   endtask
   // ----
   // sequence
   // ----
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {control_port_enable, powerdown_chan_a, powerdown_chan_b, test_pattern_select} = '0;
      {word_align_select, lane_config_select} = '0;
      sample_valid = 1'b1;
      sample_chan_a = SMP_A;
      sample_chan_b = SMP_B;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      axi_rd(ADDR_CTRL, d, r);
      chk(d, 32'h0000_0000, "ctrl reset value");
      axi_rd(4'h8, d, r);
      chk(r, RESP_SLVERR, "unmapped read");
      axi_wr(4'hc, 32'h0000_001f, r);
      chk(r, RESP_SLVERR, "unmapped write");
      axi_wr(ADDR_CTRL, 32'hffff_ffe4, r);
      chk(r, RESP_OKAY, "ctrl write response");
      axi_rd(ADDR_CTRL, d, r);
      chk(d, 32'h0000_0004, "ctrl readback");
      chk(r, RESP_OKAY, "ctrl read response");
      $display("test registers done");
      @(posedge clk);
      test_pattern_select <= 1'b1;
      wait_words(4);
      chk(cap_r[0], TEST_WORD, "lane1 a pattern");
      chk(cap_r[1], TEST_WORD, "lane1 b pattern");
      chk(cap_f[3], TEST_WORD, "lane0 b pattern");
      axi_rd(ADDR_STATUS, d, r);
      chk(d & 32'h0000_003f, 32'h0000_0004, "status test");
      $display("test pattern done");
      @(posedge clk);
      test_pattern_select <= 1'b0;
      wait_words(4);
      chk(cap_r[0], SMP_A, "lane1 a sample");
      chk(cap_r[1], SMP_B, "lane1 b sample");
      chk(cap_f[2], SMP_A, "lane0 a offset");
      chk(cap_f[3], SMP_B, "lane0 b offset");
      chk({lane0_oe_chan_a, lane0_oe_chan_b}, 2'b11, "lane0 driven");
      t0 = tog;
      repeat (24) @(posedge link_clk);
      chk(tog - t0, 24, "clock toggles");
      @(posedge clk);
      word_align_select <= 1'b1;
      wait_words(4);
      chk(cap_r[2], SMP_A, "lane0 a aligned");
      chk(cap_r[3], SMP_B, "lane0 b aligned");
      $display("test dual lane done");
      @(posedge clk);
      word_align_select <= 1'b0;
      lane_config_select <= 1'b1;
      wait_words(4);
      chk(cap_r[0], SMP_A, "single lane a");
      chk(cap_r[1], SMP_B, "single lane b");
      chk({lane0_oe_chan_a, lane0_oe_chan_b}, 2'b00, "lane0 released");
      @(posedge clk);
      lane_config_select <= 1'b0;
      $display("test single lane done");
      @(posedge clk);
      control_port_enable <= 1'b1;
      {powerdown_chan_a, powerdown_chan_b} <= 2'b11;
      wait_words(4);
      chk(cap_r[0], TEST_WORD, "ctrl overrides pins");
      axi_rd(ADDR_STATUS, d, r);
      chk(d & 32'h0000_003f, 32'h0000_0024, "status control");
      $display("test control port done");
      @(posedge clk);
      control_port_enable <= 1'b0;
      repeat (20) @(posedge link_clk);
      held = {lane1_data_chan_a, lane1_data_chan_b};
      t0 = tog;
      repeat (24) @(posedge link_clk);
      chk(tog - t0, 0, "clock stopped");
      chk({serial_out_clock, frame_out}, 2'b00, "clock frame low");
      chk({lane1_data_chan_a, lane1_data_chan_b}, held, "lanes frozen");
      chk(lane0_oe_chan_a, 1'b1, "lane0 kept driven");
      @(posedge clk);
      powerdown_chan_b <= 1'b0;
      wait_words(4);
      chk(cap_r[1], SMP_B, "chan b runs");
      chk(cap_r[0], {12{lane1_data_chan_a}}, "chan a frozen");
      $display("test power-down done");
      complete_run();
   end
endmodule
`default_nettype wire
